// ### rtl/ftpc_top.sv
// Module: fan speed-sense pulse counter with pulse-count configuration
// Functional notes
// - Bits 1:0 pick first fan pulses
// - Bits 3:2 pick second fan pulses
// - Bits 5:4 pick third fan pulses
// - Bits 7:6 pick fourth fan pulses
// - Register resets to 0x55, two pulses
`default_nettype none
module ftpc_top (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire ftpc_pkg::ftpc_req_t req,
    output logic [7:0]               rd_data,
    output logic                     rd_valid,
    input  wire logic [3:0]          speed_sense_input,
    input  wire logic [3:0]          meas_start,
    output logic [3:0]               meas_busy,
    output logic [3:0]               meas_done,
    output logic [7:0]               pulse_sel
);
    // ************************************************
    // Helpers
    // ************************************************
    // Field of one fan out of the register
    function automatic logic [1:0] fan_field(input logic [7:0] cfg,
                                             input int         idx);
        logic [1:0] f;
        f = 2'h0;
        case (idx)
            0: f = cfg[ftpc_pkg::FTPC_FIRST_FAN_PULSE_SEL_LSB +: ftpc_pkg::FTPC_FIELD_W];
            1: f = cfg[ftpc_pkg::FTPC_SECOND_FAN_PULSE_SEL_LSB +: ftpc_pkg::FTPC_FIELD_W];
            2: f = cfg[ftpc_pkg::FTPC_THIRD_FAN_PULSE_SEL_LSB +: ftpc_pkg::FTPC_FIELD_W];
            default:
               f = cfg[ftpc_pkg::FTPC_FOURTH_FAN_PULSE_SEL_LSB +: ftpc_pkg::FTPC_FIELD_W];
        endcase
        return f;
    endfunction

    // ************************************************
    // Configuration register
    // ************************************************
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic       rd_valid_reg;
    logic       rd_valid_next;
    logic       hit;

    assign hit = (req.addr == ftpc_pkg::FTPC_CFG_OFFSET);

    // Write, read-back and unmapped reads as zero
    always_comb begin
        cfg_next      = cfg_reg;
        rd_data_next  = rd_data_reg;
        rd_valid_next = req.rd;
        if (req.wr && hit) begin
            cfg_next = req.wdata;
        end
        if (req.rd) begin
            rd_data_next = hit ? cfg_reg : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cfg_reg      <= ftpc_pkg::FTPC_CFG_RESET;
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign rd_data   = rd_data_reg;
    assign rd_valid  = rd_valid_reg;
    assign pulse_sel = cfg_reg;

    // ************************************************
    // Speed-sense synchronisers
    // ************************************************
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] lvl_reg;
    logic [3:0] lvl_next;
    logic [3:0] rise;

    // Level accepted once second and third stages agree
    always_comb begin
        lvl_next = lvl_reg;
        rise     = 4'h0;
        for (int i = 0; i < ftpc_pkg::FTPC_NUM_FANS; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
                rise[i]     = s3_reg[i] & ~lvl_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s1_reg  <= 4'h0;
            s2_reg  <= 4'h0;
            s3_reg  <= 4'h0;
            lvl_reg <= 4'h0;
        end else begin
            s1_reg  <= speed_sense_input;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    // ************************************************
    // Per-fan pulse counters
    // ************************************************
    ftpc_pkg::ftpc_fan_t fan_reg  [4];
    ftpc_pkg::ftpc_fan_t fan_next [4];
    logic [3:0]          done_reg;
    logic [3:0]          done_next;

    // Selection latched at start, held until the count completes
    always_comb begin
        done_next = 4'h0;
        for (int i = 0; i < ftpc_pkg::FTPC_NUM_FANS; i++) begin
            fan_next[i] = fan_reg[i];
            if (!fan_reg[i].busy) begin
                if (meas_start[i]) begin
                    fan_next[i].busy = 1'b1;
                    fan_next[i].tgt = fan_field(cfg_reg, i);
                    fan_next[i].cnt  = 2'h0;
                end
            end else if (rise[i]) begin
                if (fan_reg[i].cnt == fan_reg[i].tgt) begin
                    fan_next[i].busy = 1'b0;
                    done_next[i]     = 1'b1;
                end else begin
                    fan_next[i].cnt = fan_reg[i].cnt + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < ftpc_pkg::FTPC_NUM_FANS; i++) begin
                fan_reg[i] <= '0;
            end
            done_reg <= 4'h0;
        end else begin
            for (int i = 0; i < ftpc_pkg::FTPC_NUM_FANS; i++) begin
                fan_reg[i] <= fan_next[i];
            end
            done_reg <= done_next;
        end
    end

    // Busy flags and done pulses
    always_comb begin
        for (int i = 0; i < ftpc_pkg::FTPC_NUM_FANS; i++) begin
            meas_busy[i] = fan_reg[i].busy;
        end
    end
    assign meas_done = done_reg;

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    reset_value_a: assert property ($rose(rst_b) |->
        cfg_reg == ftpc_pkg::FTPC_CFG_RESET)
        else $error("register not at reset value after reset");
    rd_data_a: assert property (req.rd && hit |=>
        rd_valid && rd_data == $past(cfg_reg))
        else $error("read-back differs from register");
    other_addr_a: assert property (req.wr && !hit |=>
        cfg_reg == $past(cfg_reg))
        else $error("write to other address changed register");
    cfg_write_a: assert property (req.wr && hit |=>
        cfg_reg == $past(req.wdata))
        else $error("register write lost");
    first_fan_pulse_sel_sel_a: assert property (meas_start[0] && !fan_reg[0].busy |=>
        fan_reg[0].busy && fan_reg[0].tgt == $past(cfg_reg[1:0]))
        else $error("first fan selection wrong");
    second_fan_pulse_sel_sel_a: assert property (meas_start[1] && !fan_reg[1].busy |=>
        fan_reg[1].tgt == $past(cfg_reg[3:2]))
        else $error("second fan selection wrong");
    third_fan_pulse_sel_sel_a: assert property (meas_start[2] && !fan_reg[2].busy |=>
        fan_reg[2].tgt == $past(cfg_reg[5:4]))
        else $error("third fan selection wrong");
    fourth_fan_pulse_sel_sel_a: assert property (meas_start[3] && !fan_reg[3].busy |=>
        fan_reg[3].tgt == $past(cfg_reg[7:6]))
        else $error("fourth fan selection wrong");
    sel_hold_a: assert property (
        fan_reg[0].busy && $past(fan_reg[0].busy)
        |-> $stable(fan_reg[0].tgt))
        else $error("selection changed mid measurement");
    sel_hold4_a: assert property (
        fan_reg[3].busy && $past(fan_reg[3].busy)
        |-> $stable(fan_reg[3].tgt))
        else $error("fourth fan selection changed mid measurement");
    done_count_a: assert property (meas_done[0] |->
        $past(fan_reg[0].cnt) == $past(fan_reg[0].tgt) && !fan_reg[0].busy)
        else $error("measurement ended at wrong count");
    done_count4_a: assert property (meas_done[3] |->
        $past(fan_reg[3].cnt) == $past(fan_reg[3].tgt) && !fan_reg[3].busy)
        else $error("fourth fan ended at wrong count");

    // Main scenarios
    four_pulse_c: cover property (meas_done[0] &&
        $past(fan_reg[0].tgt) == 2'h3);
    one_pulse_c: cover property (meas_done[2] &&
        $past(fan_reg[2].tgt) == 2'h0);
    rewrite_busy_c: cover property (fan_reg[1].busy && req.wr && hit);
    all_busy_c: cover property (&meas_busy);
endmodule
`default_nettype wire

// ### rtl/ftpc_pkg.sv
// Package: constants and types for the fan pulse-count configuration block
`default_nettype none
package ftpc_pkg;
    // ************************************************
    // Register map
    // ************************************************
    localparam logic [7:0] FTPC_CFG_OFFSET = 8'h7B;  // Pulse-count register
    localparam logic [7:0] FTPC_CFG_RESET  = 8'h55;  // Two pulses per fan
    localparam int         FTPC_FIELD_W    = 2;      // Bits per fan field
    localparam int         FTPC_FIRST_FAN_PULSE_SEL_LSB   = 0;      // First fan field
    localparam int         FTPC_SECOND_FAN_PULSE_SEL_LSB   = 2;      // Second fan field
    localparam int         FTPC_THIRD_FAN_PULSE_SEL_LSB   = 4;      // Third fan field
    localparam int         FTPC_FOURTH_FAN_PULSE_SEL_LSB   = 6;      // Fourth fan field
    localparam int         FTPC_NUM_FANS   = 4;      // Speed-sense inputs

    // ************************************************
    // Per-fan measurement state
    // ************************************************
    typedef struct packed {
        logic       busy;  // Measurement in progress
        logic [1:0] tgt;   // Latched selection code
        logic [1:0] cnt;   // Rising edges seen so far
    } ftpc_fan_t;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ftpc_req_t;
endpackage
`default_nettype wire

// ### bench/ftpc_fan_model.sv
// Fan speed-sense pulse source for the bench
`default_nettype none
module ftpc_fan_model (
    input  wire logic       clk,
    input  wire logic [3:0] en,
    output logic      [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph [4];
    // Phase counters, cleared while a fan is stopped
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            ph[i] <= en[i] ? ph[i] + 3'h1 : 3'h0;
        end
    end
    // Four cycles low, then four high; a stopped fan reads low
    assign pins = en & {ph[3][2], ph[2][2], ph[1][2], ph[0][2]};
endmodule
`default_nettype wire

// ### bench/tb_fan_speed_sense_input_pulse_count_config.sv
// Self-checking bench for the fan pulse-count configuration block
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_fan_speed_sense_input_pulse_count_config;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] OFF = ftpc_pkg::FTPC_CFG_OFFSET;
    logic                clk, rst_b, rd_valid;
    ftpc_pkg::ftpc_req_t req;
    logic [7:0]          rd_data, pulse_sel;
    logic [3:0]          pins, fan_en, meas_start, meas_busy, meas_done;
    int                  num_errors, checks_done, model_reg;
    bit                  hung;

    ftpc_top u_dut (.clk(clk), .rst_b(rst_b), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid),
        .speed_sense_input(pins), .meas_start(meas_start),
        .meas_busy(meas_busy), .meas_done(meas_done),
        .pulse_sel(pulse_sel));
    ftpc_fan_model u_fan (.clk(clk), .en(fan_en), .pins(pins));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        step();
        req.wr = 1'b0;
        if (a == OFF) model_reg = d;
        step();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req.rd = 1'b1;
        req.addr = a;
        step();
        req.rd = 1'b0;
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", e, rd_data)
        step();
        `CHK("rd_valid_end", 1'b0, rd_valid)
        `CHK("rd_data_hold", e, rd_data)
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One run on all fans; a new value is written mid-run
    task automatic measure(input logic [7:0] v);
        int         edges [4];
        int         exp_q [$];
        int         n;
        logic [3:0] prev, seen;
        if (hung) return;
        wr(OFF, v);
        // Expected pulses per fan from the model register
        for (int i = 0; i < 4; i++) begin
            exp_q.push_back(((model_reg >> (2 * i)) & 3) + 1);
        end
        meas_start = 4'hF;
        step();
        meas_start = 4'h0;
        `CHK("busy", 4'hF, meas_busy)
        fan_en = 4'hF;
        wr(OFF, 8'($urandom));
        edges = '{0, 0, 0, 0};
        prev = 4'h0;
        seen = 4'h0;
        n = 0;
        while (seen !== 4'hF && n < 200) begin
            step();
            n++;
            for (int i = 0; i < 4; i++) begin
                if (pins[i] && !prev[i]) edges[i]++;
                if (meas_done[i] === 1'b1 && !seen[i]) begin
                    seen[i] = 1'b1;
                    `CHK("pulses", exp_q[i], edges[i])
                end
            end
            prev = pins;
        end
        if (n >= 200) begin
            num_errors++;
            hung = 1'b1;
        end
        `CHK("idle", 4'h0, meas_busy)
        fan_en = 4'h0;
        repeat (10) step();
    endtask

    // Main sequence
    initial begin
        void'($urandom(97));
        rst_b = 1'b0;
        req = '0;
        meas_start = 4'h0;
        fan_en = 4'h0;
        num_errors = 0;
        checks_done = 0;
        hung = 1'b0;
        model_reg = 8'h55;
        repeat (4) step();
        rst_b = 1'b1;
        `CHK("sel_rst", 8'h55, pulse_sel)
        rd(OFF, 8'h55);
        $display("test reset done");
        wr(8'h7A, 8'h00);
        rd(8'h7A, 8'h00);
        rd(OFF, 8'h55);
        for (int k = 0; k < 4; k++) begin
            wr(OFF, 8'($urandom));
            rd(OFF, model_reg[7:0]);
            `CHK("pulse_sel", model_reg[7:0], pulse_sel)
        end
        $display("test register done");
        measure(8'hE4);
        measure(8'h1B);
        measure(8'h4E);
        measure(8'hB1);
        rd(OFF, model_reg[7:0]);
        $display("test measure done");
        end_sim();
    end
endmodule
`default_nettype wire
